// ==== hw/scib_pkg.sv ====
package scib_pkg;
   // Host clock
   localparam int CLK_NS = 40;
   // Slowest programmed-I/O timing, one mode only
   localparam int SETUP_NS = 70;
   localparam int STROBE_NS = 165;
   localparam int CYCLE_NS = 600;
   localparam int RECOV_NS = CYCLE_NS - SETUP_NS - STROBE_NS;

   // Least time to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam logic [3:0] SETUP_CYC = 4'(ns_to_cyc(SETUP_NS));
   localparam logic [3:0] STROBE_CYC = 4'(ns_to_cyc(STROBE_NS));
   localparam logic [3:0] RECOV_CYC = 4'(ns_to_cyc(RECOV_NS));

   // Task-file offsets
   localparam logic [3:0] TF_LAST_CMD_OFF = 4'h7;
   localparam logic [3:0] TF_ALT_OFF = 4'hE;
   // Card select codes, active low, and the alternate-status address
   localparam logic [1:0] CS_CMD_BLOCK = 2'h2;
   localparam logic [1:0] CS_CTL_BLOCK = 2'h1;
   localparam logic [1:0] CS_NONE = 2'h3;
   localparam logic [2:0] ALT_REG_ADDR = 3'h6;

   // Control port offsets
   localparam logic [1:0] CTL_CARD_OFF = 2'h0;
   localparam logic [1:0] CTL_IFACE_OFF = 2'h1;

   // Card control fields
   localparam int CC_DET_BIT = 0;
   localparam int CC_PWR_BIT = 1;
   localparam int CC_RST_BIT = 2;
   localparam int CC_PRESENCE_CHANGE_IRQ_ENABLE_BIT = 3;
   // Interface control field
   localparam int IC_CARD_IRQ_ENABLE_BIT = 0;

   // Reset values
   localparam logic PWR_RESET = 1'b0;
   localparam logic CRST_RESET = 1'b1;
   localparam logic PRESENCE_CHANGE_IRQ_ENABLE_RESET = 1'b0;
   localparam logic CARD_IRQ_ENABLE_RESET = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_SETUP = 3'h1,
      ST_STROBE = 3'h2,
      ST_DONE = 3'h3,
      ST_RECOV = 3'h4
   } scib_state_t;
endpackage

// ==== hw/scib_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module scib_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // Two flops; the first is read by the second only
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== hw/scib_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// How it works
// - offsets 0-6 reach the card's task registers
// - offset 7 status/command, 14 alt-status/control
// - card control at 0, interface at 1
// - reading card control clears pending interrupt
// - bit 0 read-only card detected
// - bit 1 switches card power
// - bit 2 holds card in reset
// - bit 3 enables presence-change interrupt
// - interface bit 0 relays card interrupt
// - two separate active-high interrupt outputs
// - card cycles use slowest I/O timing only
module scib_top (
   input wire logic clock,
   input wire logic rst,
   // Task-file port
   input wire logic [3:0] tf_addr,
   input wire logic tf_read,
   input wire logic tf_write,
   input wire logic [15:0] tf_wdata,
   output logic [15:0] tf_rdata,
   output logic tf_waitreq,
   // Control port
   input wire logic [1:0] ctl_addr,
   input wire logic ctl_read,
   input wire logic ctl_write,
   input wire logic [31:0] ctl_wdata,
   output logic [31:0] ctl_rdata,
   output logic ctl_rvalid,
   // Interrupts
   output logic presence_irq,
   output logic card_irq,
   // Card pins
   output logic [10:0] card_addr,
   output logic [1:0] card_cs_n,
   output logic card_atasel_n,
   output logic card_we_n,
   output logic card_iord_n,
   output logic card_iowr_n,
   output logic card_reset_n,
   output logic card_power,
   input wire logic [15:0] card_data_in,
   output logic [15:0] card_data_out,
   output logic card_data_oe_n,
   input wire logic card_detect,
   input wire logic card_intrq,
   input wire logic card_iordy
);
   scib_pkg::scib_state_t state_reg;
   logic [3:0] cnt_reg;
   logic wr_reg;
   logic hit_reg;
   logic [1:0] cs_reg;
   logic [2:0] reg_sel_reg;
   logic [15:0] rd_data_reg;
   logic card_power_on_reg;
   logic card_reset_reg;
   logic presence_change_irq_enable_reg;
   logic card_irq_enable_reg;
   logic det_prev_reg;
   logic det_pend_reg;
   logic card_irq_reg;
   logic [31:0] ctl_rdata_reg;
   logic ctl_rvalid_reg;
   logic det_s;
   logic intrq_s;
   logic iordy_s;
   logic [15:0] data_s;
   logic [5:0] map;
   logic det_evt;
   logic ctl_card_rd;
   logic tf_req;

   // Map a task-file offset to {hit, chip selects, register address}
   function automatic logic [5:0] tf_map(input logic [3:0] off);
      if (off <= scib_pkg::TF_LAST_CMD_OFF) begin
         tf_map = {1'b1, scib_pkg::CS_CMD_BLOCK, off[2:0]};
      end else if (off == scib_pkg::TF_ALT_OFF) begin
         tf_map = {1'b1, scib_pkg::CS_CTL_BLOCK,
                   scib_pkg::ALT_REG_ADDR};
      end else begin
         tf_map = {1'b0, scib_pkg::CS_NONE, 3'h0};
      end
   endfunction

   // Every card input is synchronised before use
   scib_sync #(
      .WIDTH(19)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .d({card_detect, card_intrq, card_iordy, card_data_in}),
      .q({det_s, intrq_s, iordy_s, data_s})
   );

   assign map = tf_map(tf_addr);
   assign tf_req = tf_read | tf_write;
   assign det_evt = det_s != det_prev_reg;
   assign ctl_card_rd = ctl_read && (ctl_addr == scib_pkg::CTL_CARD_OFF);

   // Card cycle sequencer: setup, strobe, answer, recovery
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= scib_pkg::ST_IDLE;
         cnt_reg <= 4'h0;
      end else begin
         unique case (state_reg)
            scib_pkg::ST_IDLE: begin
               if (tf_req && map[5]) begin
                  state_reg <= scib_pkg::ST_SETUP;
                  cnt_reg <= scib_pkg::SETUP_CYC - 4'h1;
               end else if (tf_req) begin
                  state_reg <= scib_pkg::ST_DONE;
               end
            end
            scib_pkg::ST_SETUP: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= scib_pkg::ST_STROBE;
                  cnt_reg <= scib_pkg::STROBE_CYC - 4'h1;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            scib_pkg::ST_STROBE: begin
               // Minimum width first, then wait on ready
               if (cnt_reg != 4'h0) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else if (iordy_s) begin
                  state_reg <= scib_pkg::ST_DONE;
               end
            end
            scib_pkg::ST_DONE: begin
               state_reg <= hit_reg ? scib_pkg::ST_RECOV : scib_pkg::ST_IDLE;
               cnt_reg <= scib_pkg::RECOV_CYC - 4'h1;
            end
            scib_pkg::ST_RECOV: begin
               if (cnt_reg == 4'h0) begin
                  state_reg <= scib_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= scib_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Request latched at start; host holds it anyway until answered
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_reg <= 1'b0;
         hit_reg <= 1'b0;
         cs_reg <= scib_pkg::CS_NONE;
         reg_sel_reg <= 3'h0;
         card_data_out <= 16'h0000;
      end else if (state_reg == scib_pkg::ST_IDLE && tf_req) begin
         wr_reg <= tf_write;
         hit_reg <= map[5];
         cs_reg <= map[4:3];
         reg_sel_reg <= map[2:0];
         card_data_out <= tf_wdata;
      end else if (state_reg == scib_pkg::ST_RECOV) begin
         cs_reg <= scib_pkg::CS_NONE;
      end
   end

   // Read data sampled while strobe is still low
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data_reg <= 16'h0000;
      end else if (state_reg == scib_pkg::ST_STROBE && cnt_reg == 4'h0
                   && iordy_s) begin
         rd_data_reg <= data_s;
      end else if (state_reg == scib_pkg::ST_IDLE && tf_req && !map[5]) begin
         rd_data_reg <= 16'h0000; // Unmapped offsets read zero
      end
   end

   // Strobes decode from the state and write flops only, so they stay clean
   assign card_iord_n = !(state_reg == scib_pkg::ST_STROBE && !wr_reg);
   assign card_iowr_n = !(state_reg == scib_pkg::ST_STROBE && wr_reg);
   // Drive data from setup to answer on writes only
   assign card_data_oe_n = !(wr_reg && (state_reg == scib_pkg::ST_SETUP
      || state_reg == scib_pkg::ST_STROBE
      || state_reg == scib_pkg::ST_DONE));
   assign card_cs_n = cs_reg;
   assign card_addr = {8'h00, reg_sel_reg};
   assign card_atasel_n = 1'b0; // True IDE mode
   assign card_we_n = 1'b1;
   assign tf_rdata = rd_data_reg;
   assign tf_waitreq = tf_req && state_reg != scib_pkg::ST_DONE;

   // Control registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         card_power_on_reg <= scib_pkg::PWR_RESET;
         card_reset_reg <= scib_pkg::CRST_RESET;
         presence_change_irq_enable_reg <= scib_pkg::PRESENCE_CHANGE_IRQ_ENABLE_RESET;
         card_irq_enable_reg <= scib_pkg::CARD_IRQ_ENABLE_RESET;
      end else if (ctl_write) begin
         if (ctl_addr == scib_pkg::CTL_CARD_OFF) begin
            card_power_on_reg <= ctl_wdata[scib_pkg::CC_PWR_BIT];
            card_reset_reg <= ctl_wdata[scib_pkg::CC_RST_BIT];
            presence_change_irq_enable_reg <=
               ctl_wdata[scib_pkg::CC_PRESENCE_CHANGE_IRQ_ENABLE_BIT];
         end else if (ctl_addr == scib_pkg::CTL_IFACE_OFF) begin
            card_irq_enable_reg <= ctl_wdata[scib_pkg::IC_CARD_IRQ_ENABLE_BIT];
         end
      end
   end

   assign card_power = card_power_on_reg;
   assign card_reset_n = !card_reset_reg;

   // Control read data, one cycle after the read; reserved words are zero
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctl_rdata_reg <= 32'h00000000;
         ctl_rvalid_reg <= 1'b0;
      end else begin
         ctl_rvalid_reg <= ctl_read;
         if (ctl_read) begin
            ctl_rdata_reg <= 32'h00000000;
            if (ctl_addr == scib_pkg::CTL_CARD_OFF) begin
               ctl_rdata_reg[scib_pkg::CC_DET_BIT] <= det_s;
               ctl_rdata_reg[scib_pkg::CC_PWR_BIT] <= card_power_on_reg;
               ctl_rdata_reg[scib_pkg::CC_RST_BIT] <= card_reset_reg;
               ctl_rdata_reg[scib_pkg::CC_PRESENCE_CHANGE_IRQ_ENABLE_BIT] <=
                  presence_change_irq_enable_reg;
            end else if (ctl_addr == scib_pkg::CTL_IFACE_OFF) begin
               ctl_rdata_reg[scib_pkg::IC_CARD_IRQ_ENABLE_BIT] <= card_irq_enable_reg;
            end
         end
      end
   end

   assign ctl_rdata = ctl_rdata_reg;
   assign ctl_rvalid = ctl_rvalid_reg;

   // Presence change is sticky while enabled; a new enabled change beats the read clear
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         det_prev_reg <= 1'b0;
         det_pend_reg <= 1'b0;
      end else begin
         det_prev_reg <= det_s;
         if (det_evt && presence_change_irq_enable_reg) begin
            det_pend_reg <= 1'b1;
         end else if (ctl_card_rd) begin
            det_pend_reg <= 1'b0;
         end
      end
   end

   // Card interrupt relayed as a level, one flop late
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         card_irq_reg <= 1'b0;
      end else begin
         card_irq_reg <= card_irq_enable_reg && intrq_s;
      end
   end

   assign presence_irq = det_pend_reg;
   assign card_irq = card_irq_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_tf_addr_map: assert property (
      state_reg == scib_pkg::ST_IDLE && tf_req
      && tf_addr <= scib_pkg::TF_LAST_CMD_OFF
      |=> card_cs_n == scib_pkg::CS_CMD_BLOCK
      && card_addr[2:0] == $past(tf_addr[2:0]))
      else $error("task register offset mapped wrong");
   a_alt_status_map: assert property (
      state_reg == scib_pkg::ST_IDLE && tf_req
      && tf_addr == scib_pkg::TF_ALT_OFF
      |=> card_cs_n == scib_pkg::CS_CTL_BLOCK
      && card_addr[2:0] == scib_pkg::ALT_REG_ADDR)
      else $error("alternate status mapped wrong");
   a_iface_readback: assert property (
      ctl_read && ctl_addr == scib_pkg::CTL_IFACE_OFF
      |=> ctl_rvalid && ctl_rdata == {31'h0, $past(card_irq_enable_reg)})
      else $error("interface control readback wrong");
   a_read_clears: assert property (
      ctl_card_rd && !det_evt |=> !presence_irq)
      else $error("card control read did not clear interrupt");
   a_detect_bit: assert property (
      ctl_card_rd |=> ctl_rdata[scib_pkg::CC_DET_BIT] == $past(det_s))
      else $error("detect bit does not follow card");
   a_power_out: assert property (
      ctl_write && ctl_addr == scib_pkg::CTL_CARD_OFF
      |=> card_power == $past(ctl_wdata[scib_pkg::CC_PWR_BIT]))
      else $error("power output does not follow write");
   a_card_reset: assert property (
      ctl_write && ctl_addr == scib_pkg::CTL_CARD_OFF
      |=> card_reset_n == !$past(ctl_wdata[scib_pkg::CC_RST_BIT]))
      else $error("card reset does not follow write");
   a_det_irq_set: assert property (
      det_evt && presence_change_irq_enable_reg |=> presence_irq)
      else $error("presence change not signalled");
   a_card_irq_relay: assert property (
      card_irq_enable_reg && intrq_s |=> card_irq)
      else $error("card interrupt not relayed");
   a_presence_hold: assert property (
      !(det_evt && presence_change_irq_enable_reg) && !ctl_card_rd
      |=> presence_irq == $past(presence_irq))
      else $error("presence interrupt moved without its event");
   a_irq_separate: assert property (
      !card_irq_enable_reg && !$past(card_irq_enable_reg) |=> !card_irq)
      else $error("card interrupt leaks while disabled");
   a_strobe_width: assert property (
      $rose(state_reg == scib_pkg::ST_STROBE)
      |-> (!(card_iord_n && card_iowr_n))[*5])
      else $error("strobe shorter than mode 0 width");
   a_bus_drive: assert property (
      !card_data_oe_n |-> wr_reg && card_iord_n)
      else $error("data driven during a read");
   a_strobe_ready: assert property (
      state_reg == scib_pkg::ST_STROBE && !iordy_s
      |=> state_reg == scib_pkg::ST_STROBE)
      else $error("strobe ended without ready");
endmodule
`default_nettype wire

// ==== test/scib_card_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Card end: task registers behind the strobes, ready held off on demand
module scib_card_model (
   input wire logic clock,
   input wire logic [10:0] card_addr,
   input wire logic [1:0] card_cs_n,
   input wire logic card_iord_n,
   input wire logic card_iowr_n,
   input wire logic [15:0] card_data_out,
   input wire logic card_data_oe_n,
   input wire logic [3:0] ready_delay,
   output logic [15:0] card_data_in,
   output logic card_iordy
);
   logic [15:0] regs_reg [16];
   logic [15:0] last_reg = 16'h0000;
   logic [3:0] wait_reg = 4'h0;
   logic [3:0] idx;
   logic idle;

   // Control block lands at 8 + address, the same slot as the host offset
   assign idx = {card_cs_n == 2'h1, card_addr[2:0]};
   assign idle = card_iord_n && card_iowr_n;

   // Ready stays low for ready_delay clocks of every strobe
   always @(posedge clock) begin
      if (idle) begin
         wait_reg <= 4'h0;
      end else if (wait_reg != 4'hF) begin
         wait_reg <= wait_reg + 4'h1;
      end
      if (!card_iord_n) begin
         last_reg <= regs_reg[idx];
      end
   end
   assign card_iordy = idle || (wait_reg >= ready_delay);

   // Undriven bus stores garbage, so a missing enable shows on read-back
   always @(posedge card_iowr_n) begin
      if (card_cs_n != 2'h3) begin
         regs_reg[idx] <= card_data_oe_n ? ~card_data_out : card_data_out;
      end
   end

   // Released bus shows the inverse of the last word, never a stale copy
   assign card_data_in = card_iord_n ? ~last_reg : regs_reg[idx];
endmodule
`default_nettype wire

// ==== test/storage_card_ide_bridge_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module storage_card_ide_bridge_tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] tf_addr = 4'h0;
   logic tf_read = 1'b0;
   logic tf_write = 1'b0;
   logic [15:0] tf_wdata = 16'h0000;
   logic [15:0] tf_rdata;
   logic tf_waitreq;
   logic [1:0] ctl_addr = 2'h0;
   logic ctl_read = 1'b0;
   logic ctl_write = 1'b0;
   logic [31:0] ctl_wdata = 32'h00000000;
   logic [31:0] ctl_rdata;
   logic ctl_rvalid, presence_irq, card_irq, card_atasel_n, card_we_n;
   logic [10:0] card_addr;
   logic [1:0] card_cs_n;
   logic card_iord_n, card_iowr_n, card_reset_n, card_power;
   logic card_data_oe_n, card_iordy;
   logic [15:0] card_data_in, card_data_out;
   logic card_detect = 1'b0;
   logic card_intrq = 1'b0;
   logic [3:0] ready_delay = 4'h0;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;
   int low_cnt = 0;
   logic [31:0] rnd = 32'h4687;
   logic [31:0] exp_q [$];
   logic [15:0] tf_val [16];
   logic [3:0] offs [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                            4'h7, 4'hE};

   always #20 clock = ~clock;

   scib_top DUT (.clock, .rst, .tf_addr, .tf_read, .tf_write, .tf_wdata,
      .tf_rdata, .tf_waitreq, .ctl_addr, .ctl_read, .ctl_write, .ctl_wdata,
      .ctl_rdata, .ctl_rvalid, .presence_irq, .card_irq, .card_addr,
      .card_cs_n, .card_atasel_n, .card_we_n, .card_iord_n, .card_iowr_n,
      .card_reset_n, .card_power, .card_data_in, .card_data_out,
      .card_data_oe_n, .card_detect, .card_intrq, .card_iordy);

   scib_card_model card (.clock, .card_addr, .card_cs_n, .card_iord_n,
      .card_iowr_n, .card_data_out, .card_data_oe_n, .ready_delay,
      .card_data_in, .card_iordy);

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Request held until the answer is seen, dropped on the following edge
   task automatic tf_go(input logic wr, input logic [3:0] a,
                        input logic [15:0] d);
      int n;
      @(posedge clock);
      tf_addr <= a;
      tf_read <= !wr;
      tf_write <= wr;
      tf_wdata <= d;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (tf_waitreq !== 1'b0 && n < 100);
      // A lost answer must not pass silently as a quiet write
      if (tf_waitreq !== 1'b0) begin
         n_errors++;
         $display("wrong value at %0t: access never answered", $time);
      end
      @(posedge clock);
      tf_read <= 1'b0;
      tf_write <= 1'b0;
   endtask

   // One-cycle pulse; a new call waits an edge, so no double assignment
   task automatic ctl_go(input logic wr, input logic [1:0] a,
                         input logic [31:0] d);
      @(posedge clock);
      ctl_addr <= a;
      ctl_read <= !wr;
      ctl_write <= wr;
      ctl_wdata <= d;
      @(posedge clock);
      ctl_read <= 1'b0;
      ctl_write <= 1'b0;
   endtask

   task automatic ctl_rd(input logic [1:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      ctl_go(1'b0, a, 32'h00000000);
   endtask

   // Watcher: every read answer takes the oldest note; strobes are measured
   always @(negedge clock) begin
      if (tf_read === 1'b1 && tf_waitreq === 1'b0) begin
         chk({16'h0000, tf_rdata},
             exp_q.size() ? exp_q.pop_front() : 'X);
      end
      if (ctl_rvalid === 1'b1) begin
         chk(ctl_rdata, exp_q.size() ? exp_q.pop_front() : 'X);
      end
      if (!card_iord_n || !card_iowr_n) begin
         low_cnt++;
      end else if (low_cnt != 0) begin
         chk(32'(low_cnt >= scib_pkg::STROBE_CYC && low_cnt > ready_delay),
             32'h1);
         low_cnt = 0;
      end
   end

   // Hang guard, well above the thousand or so cycles the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      chk(32'({card_reset_n, card_power, card_cs_n, card_iord_n, card_iowr_n,
               card_atasel_n, card_we_n, card_data_oe_n}), 32'h7B);
      ctl_rd(2'h0, 32'h4);
      ctl_rd(2'h1, 32'h0);
      for (int a = 2; a < 4; a++) begin
         ctl_go(1'b1, 2'(a), 32'hFFFFFFFF);
         ctl_rd(2'(a), 32'h0);
      end
      ctl_go(1'b1, 2'h0, 32'hF);
      ctl_rd(2'h0, 32'hE);
      @(negedge clock);
      chk(32'({card_power, card_reset_n}), 32'h2);
      $display("control registers done");
      // Insertion with the enable off, then removal with it on
      ctl_go(1'b1, 2'h0, 32'h2);
      card_detect <= 1'b1;
      repeat (6) @(posedge clock);
      // Outputs are read mid-cycle, away from the edge that moves them
      @(negedge clock);
      chk(32'(presence_irq), 32'h0);
      ctl_rd(2'h0, 32'h3);
      ctl_go(1'b1, 2'h0, 32'hA);
      card_detect <= 1'b0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      chk(32'({presence_irq, card_irq, card_reset_n}), 32'h5);
      ctl_rd(2'h0, 32'hA);
      @(negedge clock);
      chk(32'(presence_irq), 32'h0);
      $display("presence interrupt done");
      ctl_go(1'b1, 2'h1, 32'h1);
      card_intrq <= 1'b1;
      repeat (5) @(posedge clock);
      @(negedge clock);
      chk(32'({presence_irq, card_irq}), 32'h1);
      ctl_rd(2'h1, 32'h1);
      ctl_go(1'b1, 2'h1, 32'h0);
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(32'(card_irq), 32'h0);
      @(posedge clock);
      card_intrq <= 1'b0;
      $display("card interrupt done");
      // Distinct words to every task register, back to back, random delay
      for (int r = 0; r < 2; r++) begin
         foreach (offs[i]) begin
            rnd = xs(rnd);
            ready_delay <= {1'b0, rnd[18:16]};
            tf_val[offs[i]] = rnd[15:0];
            tf_go(1'b1, offs[i], rnd[15:0]);
         end
         tf_go(1'b1, 4'h8, 16'h1234);
         exp_q.push_back(32'h0);
         tf_go(1'b0, 4'h9, 16'h0000);
         foreach (offs[i]) begin
            rnd = xs(rnd);
            ready_delay <= {1'b0, rnd[18:16]};
            exp_q.push_back({16'h0000, tf_val[offs[i]]});
            tf_go(1'b0, offs[i], 16'h0000);
         end
      end
      $display("task file done");
      repeat (4) @(posedge clock);
      // Notes left over mean an answer never came back
      if (exp_q.size() != 0) begin
         n_errors++;
         $display("wrong value at %0t: %0d answers missing", $time,
                  exp_q.size());
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
